/* ctrl_consts.svh */
// register indices, field positions and reset values of the control/status group
// included by the three module files of the group; definitions only
`ifndef CTRL_CONSTS_SVH
`define CTRL_CONSTS_SVH

`define IDX_STATUS_CMD 7'h00
`define IDX_ADDR_LOW 7'h01
`define IDX_ADDR_HIGH 7'h02
`define IDX_MASKS 7'h03

`define B_ERR_SUM 15
`define B_OVERLEN 14
`define B_SQE_ERR 13
`define B_LOST 12
`define B_BUS_ERR 11
`define B_RX_DONE 10
`define B_TX_DONE 9
`define B_SETUP_DONE 8
`define B_IRQ_SUM 7
`define B_IRQ_EN 6
`define B_RX_ACT 5
`define B_TX_ACT 4
`define B_POLL_NOW 3
`define B_HALT 2
`define B_BEGIN 1
`define B_INIT 0

`define M_OVERLEN 14
`define M_LOST 12
`define M_BUS_ERR 11
`define M_RX_DONE 10
`define M_TX_DONE 9
`define M_SETUP_DONE 8
`define B_UNDERRUN_RECOVER 6

`define RST_WORD 16'h0000
`define RST_INDEX 7'h00

`endif

/* ctrl_pkg.sv */
// types shared by the control/status register group
// assumes ctrl_consts.svh carries the numbers
package ctrl_pkg;

	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
		logic [15:0] shadow_lo;
		logic [15:0] shadow_hi;
	} addr_state_t;

	typedef struct packed {
		logic [6:0] index;
		logic rx_done;
		logic tx_done;
		logic setup_done;
		logic irq_en;
		logic rx_on;
		logic tx_on;
		logic poll_now;
		logic halt;
		logic begin_run;
		logic init;
		logic setup_busy;
		logic begin_pending;
		logic [5:0] masks;
		logic recover;
		logic irq_sum;
		logic err_sum;
		logic irq;
		logic [15:0] rdata;
		logic setup_start;
		logic skip_frame;
	} ctrl_state_t;

endpackage

/* ctrl_link_if.sv */
// signals between the top of the register group and its two helpers
// one clock; the top drives requests, helpers answer
`timescale 1ns/10ps
`default_nettype none
interface ctrl_link_if;
	logic addr_lo_wr;
	logic addr_hi_wr;
	logic [15:0] wdata;
	logic [15:0] addr_lo;
	logic [15:0] addr_hi;
	logic [15:0] shadow_lo;
	logic [15:0] shadow_hi;
	logic [9:0] sources;
	logic [5:0] masks;
	logic summary;
	modport addr_side(input addr_lo_wr, addr_hi_wr, wdata,
		output addr_lo, addr_hi, shadow_lo, shadow_hi);
	modport irq_side(input sources, masks, output summary);
	modport top_side(output addr_lo_wr, addr_hi_wr, wdata, sources, masks,
		input addr_lo, addr_hi, shadow_lo, shadow_hi, summary);
endinterface
`default_nettype wire

/* setup_addr_regs.sv */
// setup-block address, low word and high byte, each with a shadow copy
// write strobes arrive already gated by halt/suspend from the top
`timescale 1ns/10ps
`default_nettype none
`include "ctrl_consts.svh"
module setup_addr_regs
	import ctrl_pkg::*;
(
	input wire logic core_clk_in,
	ctrl_link_if.addr_side link
);
	addr_state_t st_q;
	addr_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (link.addr_lo_wr) begin
			// bit zero always reads zero
			st_d.lo = {link.wdata[15:1], 1'b0}; // see RULE_18
			st_d.shadow_lo = {link.wdata[15:1], 1'b0}; // see RULE_18
		end
		if (link.addr_hi_wr) begin
			st_d.hi = {8'h00, link.wdata[7:0]}; // see RULE_19
			st_d.shadow_hi = {8'h00, link.wdata[7:0]}; // see RULE_18
		end
	end

	// no reset on purpose: the address survives the reset pin
	always_ff @(posedge core_clk_in) begin
		st_q <= st_d; // see RULE_18
	end

	assign link.addr_lo = st_q.lo;
	assign link.addr_hi = st_q.hi;
	assign link.shadow_lo = st_q.shadow_lo;
	assign link.shadow_hi = st_q.shadow_hi;

	property p_lo_shadow_follows;
		@(posedge core_clk_in) link.addr_lo_wr |=> link.shadow_lo == ($past(link.wdata) & 16'hfffe)
			&& link.addr_lo == ($past(link.wdata) & 16'hfffe);
	endproperty
	a_lo_shadow_follows: assert property (p_lo_shadow_follows) // see RULE_18
		else $error("low shadow not updated with the low address");
endmodule
`default_nettype wire

/* irq_summary.sv */
// masked OR of every interrupt source into one summary level
// source order: overlen, lost, bus err, lost ovf, coll ovf, rx, tx, setup, jabber, tx begun
`timescale 1ns/10ps
`default_nettype none
`include "ctrl_consts.svh"
module irq_summary
	import ctrl_pkg::*;
(
	ctrl_link_if.irq_side link
);
	logic [9:0] mask_wide;
	logic [9:0] live;

	// counter overflows, jabber and tx begun have no mask here
	assign mask_wide = {link.masks[5:3], 2'b00, link.masks[2:0], 2'b00}; // see RULE_20

	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_src
			assign live[g] = link.sources[g] & ~mask_wide[g];
		end
	endgenerate

	assign link.summary = |live; // see RULE_04
endmodule
`default_nettype wire

/* ctrl_status_irq_regs.sv */
// control/status/interrupt register group reached through an index port and a data port
// event inputs are one-cycle pulses from the buffer engine, all synchronous to core_clk_in
//
// Overview of operation
// RULE_01 - rx done flag sets on received frame handed back; write one clears
// RULE_02 - tx done flag sets on sent frame handed back; write one clears
// RULE_03 - setup done sets once setup block read; cleared by one, reset, halt
// RULE_04 - summary flag is OR of all unmasked interrupt sources, falls with them
// RULE_05 - interrupt output only while enable bit and summary flag both set
// RULE_06 - interrupt enable is plain read/write; reset and halt clear it
// RULE_07 - receiver active after begin unless rx disabled; deferred after init
// RULE_08 - transmitter active after begin unless tx disabled; deferred after init
// RULE_09 - writing one to poll-now makes the ring be fetched at once
// RULE_10 - poll-now written while transmitter inactive is dropped, no fetch
// RULE_11 - poll-now clears on descriptor fetch, reset or halt
// RULE_12 - with auto polling off, software must write poll-now to transmit
// RULE_13 - halt stops all external activity until begin or init
// RULE_14 - halt written with begin and init wins; those are ignored
// RULE_15 - halt set by reset or writing one; cleared by begin or init
// RULE_16 - begin enables tx, rx, buffer work and clears halt; init first
// RULE_17 - init starts setup read, clears halt, stays set till reset/halt
// RULE_18 - setup address low word bit0 zero, high byte, shadows, keeps on reset
// RULE_19 - address registers usable only in halt or suspend; upper byte zero
// RULE_20 - mask bits for six sources keep them out of the summary
// RULE_21 - masks cleared on reset, untouched by halt
// RULE_22 - underrun stops transmitter unless recovery bit, then skip to next frame
// RULE_23 - recovery bit cleared by reset pin or reset register read, kept by halt
// RULE_24 - host writes register index first, then uses the data port
// RULE_25 - error summary is OR of sqe, lost frame, overlength, bus error
`timescale 1ns/10ps
`default_nettype none
`include "ctrl_consts.svh"
module ctrl_status_irq_regs
	import ctrl_pkg::*;
#(
	parameter int IDX_W = 7
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic index_wr_in,
	input wire logic [15:0] index_wdata_in,
	input wire logic data_wr_in,
	input wire logic data_rd_in,
	input wire logic [15:0] data_wdata_in,
	input wire logic reset_reg_rd_in,
	input wire logic rx_frame_done_in,
	input wire logic tx_frame_done_in,
	input wire logic setup_read_done_in,
	input wire logic tx_desc_fetch_in,
	input wire logic tx_underrun_in,
	input wire logic overlength_tx_flag_in,
	input wire logic sqe_test_error_in,
	input wire logic lost_frame_flag_in,
	input wire logic bus_grant_error_flag_in,
	input wire logic lost_count_overflow_in,
	input wire logic rx_collision_count_overflow_in,
	input wire logic jabber_flag_in,
	input wire logic tx_begun_flag_in,
	input wire logic suspend_bit_in,
	input wire logic rx_disable_mode_in,
	input wire logic tx_disable_mode_in,
	output logic [15:0] data_rdata_out,
	output logic irq_out,
	output logic halted_out,
	output logic receiver_active_out,
	output logic transmitter_active_out,
	output logic tx_poll_now_out,
	output logic setup_start_out,
	output logic tx_skip_to_frame_out,
	output logic [23:0] setup_block_address_out
);
	generate
		if (IDX_W != 7) begin : g_bad_idx
			$error("index port is seven bits wide");
		end
	endgenerate

	ctrl_state_t st_q;
	ctrl_state_t st_d;
	ctrl_link_if link();

	setup_addr_regs u_addr (
		.core_clk_in(core_clk_in),
		.link(link.addr_side)
	);

	irq_summary u_irq (
		.link(link.irq_side)
	);

	logic wr_status;
	logic wr_masks;
	logic addr_open;
	logic [15:0] w;
	logic [15:0] status_word;
	logic [15:0] masks_word;
	logic err_now;

	assign w = data_wdata_in;
	// host must load the index before touching the data port
	assign wr_status = data_wr_in && st_q.index == `IDX_STATUS_CMD; // see RULE_24
	assign wr_masks = data_wr_in && st_q.index == `IDX_MASKS;
	assign addr_open = st_q.halt || suspend_bit_in; // see RULE_19
	assign link.addr_lo_wr = data_wr_in && addr_open && st_q.index == `IDX_ADDR_LOW;
	assign link.addr_hi_wr = data_wr_in && addr_open && st_q.index == `IDX_ADDR_HIGH;
	assign link.wdata = w;
	assign link.masks = st_q.masks;
	assign link.sources = {overlength_tx_flag_in, lost_frame_flag_in, bus_grant_error_flag_in,
		lost_count_overflow_in, rx_collision_count_overflow_in, st_q.rx_done, st_q.tx_done,
		st_q.setup_done, jabber_flag_in, tx_begun_flag_in};
	assign err_now = sqe_test_error_in | lost_frame_flag_in | overlength_tx_flag_in
		| bus_grant_error_flag_in; // see RULE_25

	always_comb begin
		status_word = `RST_WORD;
		status_word[`B_ERR_SUM] = st_q.err_sum;
		status_word[`B_OVERLEN] = overlength_tx_flag_in;
		status_word[`B_SQE_ERR] = sqe_test_error_in;
		status_word[`B_LOST] = lost_frame_flag_in;
		status_word[`B_BUS_ERR] = bus_grant_error_flag_in;
		status_word[`B_RX_DONE] = st_q.rx_done;
		status_word[`B_TX_DONE] = st_q.tx_done;
		status_word[`B_SETUP_DONE] = st_q.setup_done;
		status_word[`B_IRQ_SUM] = st_q.irq_sum;
		status_word[`B_IRQ_EN] = st_q.irq_en;
		status_word[`B_RX_ACT] = st_q.rx_on;
		status_word[`B_TX_ACT] = st_q.tx_on;
		status_word[`B_POLL_NOW] = st_q.poll_now;
		status_word[`B_HALT] = st_q.halt;
		status_word[`B_BEGIN] = st_q.begin_run;
		status_word[`B_INIT] = st_q.init;
		masks_word = `RST_WORD;
		masks_word[`M_OVERLEN] = st_q.masks[5];
		masks_word[`M_LOST] = st_q.masks[4];
		masks_word[`M_BUS_ERR] = st_q.masks[3];
		masks_word[`M_RX_DONE] = st_q.masks[2];
		masks_word[`M_TX_DONE] = st_q.masks[1];
		masks_word[`M_SETUP_DONE] = st_q.masks[0];
		masks_word[`B_UNDERRUN_RECOVER] = st_q.recover;
	end

	always_comb begin
		st_d = st_q;
		st_d.setup_start = 1'b0;
		st_d.skip_frame = 1'b0;
		if (index_wr_in) begin
			st_d.index = index_wdata_in[6:0]; // see RULE_24
		end
		if (wr_status) begin
			// clears first; event sets below win in the same cycle
			if (w[`B_RX_DONE]) begin
				st_d.rx_done = 1'b0; // see RULE_01
			end
			if (w[`B_TX_DONE]) begin
				st_d.tx_done = 1'b0; // see RULE_02
			end
			if (w[`B_SETUP_DONE]) begin
				st_d.setup_done = 1'b0; // see RULE_03
			end
			if (w[`B_HALT]) begin
				// halt wins over begin and init written with it
				st_d.halt = 1'b1; // see RULE_14
				st_d.begin_run = 1'b0;
				st_d.init = 1'b0;
				st_d.setup_busy = 1'b0;
				st_d.begin_pending = 1'b0;
				st_d.rx_done = 1'b0; // see RULE_03
				st_d.tx_done = 1'b0;
				st_d.setup_done = 1'b0;
				st_d.irq_en = 1'b0; // see RULE_06
				st_d.rx_on = 1'b0; // see RULE_13
				st_d.tx_on = 1'b0;
				st_d.poll_now = 1'b0; // see RULE_11
			end else begin
				st_d.irq_en = w[`B_IRQ_EN]; // see RULE_06
				if (w[`B_INIT]) begin
					st_d.halt = 1'b0; // see RULE_17
					st_d.init = 1'b1;
					st_d.setup_busy = 1'b1;
					st_d.setup_start = 1'b1;
					// begin waits for the setup read to finish
					st_d.begin_pending = w[`B_BEGIN] | st_q.begin_pending; // see RULE_16
				end else if (w[`B_BEGIN]) begin
					st_d.halt = 1'b0; // see RULE_15
					st_d.begin_run = 1'b1; // see RULE_16
					st_d.rx_on = ~rx_disable_mode_in; // see RULE_07
					st_d.tx_on = ~tx_disable_mode_in; // see RULE_08
				end
				if (w[`B_POLL_NOW]) begin
					// dropped while the transmitter is off: no ring access
					st_d.poll_now = st_q.tx_on; // see RULE_10
				end
			end
		end
		if (wr_masks) begin
			st_d.masks = {w[`M_OVERLEN], w[`M_LOST], w[`M_BUS_ERR], w[`M_RX_DONE],
				w[`M_TX_DONE], w[`M_SETUP_DONE]}; // see RULE_20
			st_d.recover = w[`B_UNDERRUN_RECOVER]; // see RULE_23
		end
		if (reset_reg_rd_in) begin
			st_d.recover = 1'b0; // see RULE_23
		end
		if (tx_desc_fetch_in && !(wr_status && w[`B_POLL_NOW])) begin
			st_d.poll_now = 1'b0; // see RULE_11
		end
		if (tx_underrun_in && st_q.tx_on) begin
			if (st_q.recover) begin
				st_d.skip_frame = 1'b1; // see RULE_22
			end else begin
				st_d.tx_on = 1'b0; // see RULE_22
				st_d.poll_now = 1'b0;
			end
		end
		if (rx_frame_done_in) begin
			st_d.rx_done = 1'b1; // see RULE_01
		end
		if (tx_frame_done_in) begin
			st_d.tx_done = 1'b1; // see RULE_02
		end
		if (setup_read_done_in && st_q.setup_busy) begin
			st_d.setup_done = 1'b1; // see RULE_03
			st_d.setup_busy = 1'b0;
			// a halt written in this cycle must not be undone by the deferred begin
			if (st_q.begin_pending && !(wr_status && w[`B_HALT])) begin
				st_d.begin_pending = 1'b0;
				st_d.begin_run = 1'b1; // see RULE_16
				st_d.rx_on = ~rx_disable_mode_in; // see RULE_07
				st_d.tx_on = ~tx_disable_mode_in; // see RULE_08
			end
		end
		// summary tracks the flags a cycle late, so it falls as they clear
		st_d.irq_sum = link.summary; // see RULE_04
		st_d.irq = st_q.irq_en && st_q.irq_sum; // see RULE_05
		st_d.err_sum = err_now; // see RULE_25
		if (data_rd_in) begin
			case (st_q.index)
				`IDX_STATUS_CMD: st_d.rdata = status_word;
				`IDX_ADDR_LOW: st_d.rdata = addr_open ? link.addr_lo : `RST_WORD; // see RULE_19
				`IDX_ADDR_HIGH: st_d.rdata = addr_open ? link.addr_hi : `RST_WORD;
				`IDX_MASKS: st_d.rdata = masks_word;
				default: st_d.rdata = `RST_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0; // see RULE_21
			st_q.halt <= 1'b1; // see RULE_15
			st_q.index <= `RST_INDEX;
		end else begin
			st_q <= st_d;
		end
	end

	assign data_rdata_out = st_q.rdata;
	assign irq_out = st_q.irq;
	assign halted_out = st_q.halt; // see RULE_13
	assign receiver_active_out = st_q.rx_on;
	assign transmitter_active_out = st_q.tx_on;
	assign tx_poll_now_out = st_q.poll_now; // see RULE_09
	assign setup_start_out = st_q.setup_start;
	assign tx_skip_to_frame_out = st_q.skip_frame;
	assign setup_block_address_out = {link.addr_hi[7:0], link.addr_lo};

	property p_rx_flag_sets;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		rx_frame_done_in |=> st_q.rx_done;
	endproperty
	a_rx_flag_sets: assert property (p_rx_flag_sets) // see RULE_01
		else $error("rx done flag missed its event");

	property p_tx_flag_clears;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		wr_status && w[`B_TX_DONE] && !tx_frame_done_in |=> !st_q.tx_done;
	endproperty
	a_tx_flag_clears: assert property (p_tx_flag_clears) // see RULE_02
		else $error("tx done flag not cleared by a written one");

	property p_irq_needs_enable;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!st_q.irq_en ##1 !st_q.irq_en |=> !irq_out;
	endproperty
	a_irq_needs_enable: assert property (p_irq_needs_enable) // see RULE_05
		else $error("interrupt raised with enable off");

	property p_irq_follows_summary;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		st_q.irq_en && st_q.irq_sum |=> irq_out;
	endproperty
	a_irq_follows_summary: assert property (p_irq_follows_summary) // see RULE_05
		else $error("interrupt not raised for enabled summary");

	property p_halt_wins;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		wr_status && w[`B_HALT] |=> halted_out && !st_q.init && !st_q.begin_run
			&& !st_q.irq_en && !receiver_active_out;
	endproperty
	a_halt_wins: assert property (p_halt_wins) // see RULE_14
		else $error("halt did not override begin and init");

	property p_begin_alone;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		wr_status && w[`B_BEGIN] && !w[`B_INIT] && !w[`B_HALT]
			|=> !halted_out && transmitter_active_out != $past(tx_disable_mode_in);
	endproperty
	a_begin_alone: assert property (p_begin_alone) // see RULE_08
		else $error("begin did not start the transmitter");

	property p_init_defers;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		wr_status && w[`B_INIT] && w[`B_BEGIN] && !w[`B_HALT] && !st_q.rx_on
			|=> setup_start_out && !receiver_active_out && st_q.init;
	endproperty
	a_init_defers: assert property (p_init_defers) // see RULE_07
		else $error("receiver started before setup read");

	property p_poll_dropped;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		wr_status && w[`B_POLL_NOW] && !st_q.tx_on |=> !tx_poll_now_out;
	endproperty
	a_poll_dropped: assert property (p_poll_dropped) // see RULE_10
		else $error("poll-now kept while transmitter off");

	property p_underrun_stop;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		tx_underrun_in && st_q.tx_on && !st_q.recover |=> !transmitter_active_out
			&& !tx_skip_to_frame_out;
	endproperty
	a_underrun_stop: assert property (p_underrun_stop) // see RULE_22
		else $error("underrun did not stop the transmitter");

	property p_recover_cleared;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		reset_reg_rd_in |=> !st_q.recover;
	endproperty
	a_recover_cleared: assert property (p_recover_cleared) // see RULE_23
		else $error("recovery bit survived reset register read");
endmodule
`default_nettype wire

/* host_model.sv */
// host side model: indexed access through the index port and the data port
// assumes the device samples on the rising edge; this model drives on the falling one
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk_in,
	input wire logic [15:0] rdata_in,
	output logic index_wr_out,
	output logic data_wr_out,
	output logic data_rd_out,
	output logic [15:0] wdata_out
);
	initial begin
		index_wr_out = 1'b0;
		data_wr_out = 1'b0;
		data_rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	// index first, data access one cycle later
	task automatic sel(input logic [6:0] idx);
		@(negedge clk_in);
		index_wr_out = 1'b1;
		wdata_out = {9'h000, idx};
		@(negedge clk_in);
		index_wr_out = 1'b0;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [15:0] d);
		sel(idx);
		wdata_out = d;
		data_wr_out = 1'b1;
		@(negedge clk_in);
		data_wr_out = 1'b0;
		// released bus shows no stale value
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [6:0] idx, output logic [15:0] d);
		sel(idx);
		wdata_out = ~wdata_out;
		data_rd_out = 1'b1;
		@(negedge clk_in);
		data_rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the control/status register group
// assumes host_model drives the register port; event pulses come from here
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [6:0] idx;
		logic [15:0] wd;
		logic [15:0] rd;
	} row_t;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic rrd = 1'b0, rxd = 1'b0, txd = 1'b0, sdone = 1'b0, fetch = 1'b0, und = 1'b0;
	logic susp = 1'b0, rxdis = 1'b0, txdis = 1'b0;
	logic [7:0] fl = 8'h00;
	logic iwr, dwr, drd, irq, hlt, rxa, txa, poll, sst, skip;
	logic [15:0] wd, rdat, v;
	logic [23:0] addr;
	int n_mismatch = 0;
	int checks = 0;
	int i;
	row_t rows[6] = '{
		'{7'h01, 16'h1235, 16'h1234}, '{7'h02, 16'h005a, 16'h005a},
		'{7'h03, 16'hffff, 16'h5f40}, '{7'h05, 16'hffff, 16'h0000},
		'{7'h00, 16'h0000, 16'h0004}, '{7'h03, 16'h0000, 16'h0000}};
	always #2 core_clk_in = ~core_clk_in;
	host_model host (.clk_in(core_clk_in), .rdata_in(rdat), .index_wr_out(iwr),
		.data_wr_out(dwr), .data_rd_out(drd), .wdata_out(wd));
	ctrl_status_irq_regs uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.index_wr_in(iwr), .index_wdata_in(wd), .data_wr_in(dwr), .data_rd_in(drd),
		.data_wdata_in(wd), .reset_reg_rd_in(rrd), .rx_frame_done_in(rxd),
		.tx_frame_done_in(txd), .setup_read_done_in(sdone), .tx_desc_fetch_in(fetch),
		.tx_underrun_in(und), .overlength_tx_flag_in(fl[0]), .sqe_test_error_in(fl[1]),
		.lost_frame_flag_in(fl[2]), .bus_grant_error_flag_in(fl[3]),
		.lost_count_overflow_in(fl[4]), .rx_collision_count_overflow_in(fl[5]),
		.jabber_flag_in(fl[6]), .tx_begun_flag_in(fl[7]), .suspend_bit_in(susp),
		.rx_disable_mode_in(rxdis), .tx_disable_mode_in(txdis), .data_rdata_out(rdat),
		.irq_out(irq), .halted_out(hlt), .receiver_active_out(rxa),
		.transmitter_active_out(txa), .tx_poll_now_out(poll), .setup_start_out(sst),
		.tx_skip_to_frame_out(skip), .setup_block_address_out(addr));
	task automatic print_verdict;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk_in);
		s = 1'b1;
		@(negedge core_clk_in);
		s = 1'b0;
	endtask
	// a hang anywhere ends the run as a failure
	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		cyc(8);
		rst_n_in = 1'b1;
		chk({hlt, irq, rxa, txa, poll, sst, skip}, 7'b1000000);
		foreach (rows[k]) begin
			host.wr(rows[k].idx, rows[k].wd);
			host.rd(rows[k].idx, v);
			chk(v, rows[k].rd);
		end
		chk(addr, 24'h5a1234);
		$display("test table done");
		for (i = 0; i < 8; i++) begin
			fl = 8'h01 << i;
			cyc(3);
			host.rd(7'h00, v);
			chk(v & 16'hf884, 16'h0004 | (i < 4 ? 16'h8000 | (16'h4000 >> i) : 16'h0000)
				| (i != 1 ? 16'h0080 : 16'h0000));
			chk(irq, 1'b0);
		end
		fl = 8'h00;
		$display("test foreign flags done");
		host.wr(7'h00, 16'h0043);
		for (i = 0; sst !== 1'b1; i++) begin
			if (i == 4) begin
				n_mismatch++;
				print_verdict();
			end
			cyc(1);
		end
		chk({hlt, rxa, txa}, 3'b000);
		host.wr(7'h01, 16'h5678);
		host.rd(7'h01, v);
		chk(v, 16'h0000);
		susp = 1'b1;
		host.rd(7'h01, v);
		chk(v, 16'h1234);
		susp = 1'b0;
		pulse(sdone);
		cyc(3);
		chk({rxa, txa, irq}, 3'b111);
		host.rd(7'h00, v);
		chk(v, 16'h01f3);
		host.wr(7'h03, 16'h0100);
		cyc(3);
		chk(irq, 1'b0);
		host.wr(7'h03, 16'h0000);
		cyc(3);
		chk(irq, 1'b1);
		host.wr(7'h00, 16'h0140);
		cyc(3);
		chk(irq, 1'b0);
		$display("test init begin done");
		for (i = 0; i < 2; i++) begin
			if (i == 0) pulse(rxd);
			else pulse(txd);
			host.wr(7'h00, 16'h0040);
			host.rd(7'h00, v);
			chk(v & 16'h0600, 16'h0400 >> i);
			host.wr(7'h00, 16'h0040 | (16'h0400 >> i));
			host.rd(7'h00, v);
			chk(v & 16'h0600, 16'h0000);
		end
		pulse(rxd);
		host.wr(7'h00, 16'h0000);
		cyc(3);
		chk(irq, 1'b0);
		host.rd(7'h00, v);
		chk(v, 16'h04b3);
		host.wr(7'h00, 16'h0400);
		$display("test event flags done");
		host.wr(7'h00, 16'h0008);
		chk(poll, 1'b1);
		pulse(fetch);
		chk(poll, 1'b0);
		pulse(und);
		chk(txa, 1'b0);
		host.wr(7'h00, 16'h0008);
		chk(poll, 1'b0);
		host.wr(7'h03, 16'h0140);
		rxdis = 1'b1;
		host.wr(7'h00, 16'h0002);
		chk({hlt, rxa, txa}, 3'b001);
		pulse(und);
		chk({skip, txa}, 2'b11);
		pulse(rrd);
		host.rd(7'h03, v);
		chk(v, 16'h0100);
		host.wr(7'h00, 16'h0007);
		chk({hlt, rxa, txa}, 3'b100);
		host.rd(7'h00, v);
		chk(v, 16'h0004);
		host.rd(7'h03, v);
		chk(v, 16'h0100);
		host.wr(7'h03, 16'h0140);
		$display("test poll underrun halt done");
		@(negedge core_clk_in);
		rst_n_in = 1'b0;
		cyc(2);
		chk({hlt, addr}, {1'b1, 24'h5a1234});
		rst_n_in = 1'b1;
		host.rd(7'h03, v);
		chk(v, 16'h0000);
		$display("test mid reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
